//--- rtl/pic_pkg.sv
// Purpose: shared constants for the cascaded interrupt controller pair
// Assumes: byte-wide I/O ports, 16-bit I/O address
// Notes: every port offset lives here; vector base and cascade fields and their 00h resets are coded in the modules
package pic_pkg;
   // ----------------------------------------------------------------
   // port map
   // ----------------------------------------------------------------
   localparam logic [15:0] MASTER_EVEN_PORT = 16'h0020;
   localparam logic [15:0] MASTER_ODD_PORT = 16'h0021;
   localparam logic [15:0] SLAVE_EVEN_PORT = 16'h00a0;
   localparam logic [15:0] SLAVE_ODD_PORT = 16'h00a1;
   localparam logic [15:0] MASTER_TRIGGER_PORT = 16'h04d0;
   localparam logic [15:0] SLAVE_TRIGGER_PORT = 16'h04d1;
   localparam logic [15:0] ALIAS_BLOCK_MASK = 16'hffe0;
   localparam logic [15:0] ALIAS_SEL_MASK = 16'h0001;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int INIT_SELECT_BIT = 4;
   localparam int LEVEL_TRIGGER_BIT = 3;
   localparam int ADDRESS_INTERVAL_BIT = 2;
   localparam int SINGLE_CASCADE_BIT = 1;
   localparam int WORD_FOUR_NEEDED_BIT = 0;
   localparam int OP_WORD_SELECT_BIT = 3;
   localparam int SPECIAL_MASK_BIT = 5;
   localparam int PROCESSOR_MODE_BIT = 0;
   // ----------------------------------------------------------------
   // reset values and recommended programming
   // ----------------------------------------------------------------
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] TRIGGER_RESET = 8'h00;
   localparam logic [7:0] INIT_WORD_FOUR_RESET = 8'h01;
   localparam logic [7:0] OP_WORD_TWO_RESET = 8'h20;
   localparam logic [7:0] OP_WORD_THREE_RESET = 8'h22;
   localparam logic [7:0] OP_WORD_THREE_RO_MASK = 8'h63;
   localparam logic [2:0] SLAVE_ADDR_RESET = 3'h7;
   localparam logic [2:0] LOWEST_PRIO_RESET = 3'h7;
   localparam logic [7:0] INIT_WORD_ONE_VALUE = 8'h11;
   localparam logic [7:0] MASTER_VECTOR_BASE = 8'h08;
   localparam logic [7:0] SLAVE_VECTOR_BASE = 8'h70;
   localparam logic [7:0] MASTER_CASCADE_VALUE = 8'h04;
   localparam logic [7:0] SLAVE_ID_VALUE = 8'h02;
   localparam logic [7:0] INIT_WORD_FOUR_VALUE = 8'h01;
   localparam logic [7:0] IDLE_READ_DATA = 8'hff;
   // init sequence states
   typedef enum logic [1:0] {
      INIT_IDLE,
      INIT_WAIT_VECTOR,
      INIT_WAIT_CASCADE,
      INIT_WAIT_FOUR
   } init_state_t;
   // host command codes
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_INIT = 2'h1;
   localparam logic [1:0] CMD_ACK = 2'h2;
endpackage

//--- rtl/pic_link_if.sv
// Purpose: I/O and acknowledge link between host and controller pair
// Assumes: one clock, all signals synchronous
// Notes: data bus split into host and device directions
`timescale 1ns/1ns
`default_nettype none
interface pic_link_if;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic [7:0] irq_lines;
   logic [7:0] slave_irq_lines;
   logic irq_acknowledge_n;
   logic [7:0] ack_vector;
   logic ack_vector_valid;
   logic cpu_irq_out;
   modport host (
      output io_addr, io_wdata, io_wr, io_rd, irq_acknowledge_n,
      input io_rdata, ack_vector, ack_vector_valid, cpu_irq_out
   );
   modport device (
      input io_addr, io_wdata, io_wr, io_rd, irq_acknowledge_n, irq_lines,
      input slave_irq_lines,
      output io_rdata, ack_vector, ack_vector_valid, cpu_irq_out
   );
endinterface
`default_nettype wire

//--- rtl/pic_unit.sv
// Purpose: one interrupt controller: init sequence, mask, vector
// Assumes: write and read strobes one cycle long
// Notes: master and slave are two instances of this module
`timescale 1ns/1ns
`default_nettype none
module pic_unit (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic even_wr_in,
   input wire logic odd_wr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] req_in,
   input wire logic [2:0] ack_level_in,
   output logic [7:0] irq_mask_out,
   output logic [7:0] op_word_three_out,
   output logic [7:0] vector_out,
   output logic [7:0] cascade_out,
   output logic initialising_out,
   output logic [7:0] pending_out
);
   import pic_pkg::*;
   init_state_t state;
   logic [7:0] vector_base;
   logic [7:0] init_four;
   logic [7:0] op_two;
   logic [2:0] slave_addr;
   logic [2:0] lowest_prio;
   logic init_start;
   assign init_start = even_wr_in && wdata_in[INIT_SELECT_BIT];
   // ----------------------------------------------------------------
   // init sequence: bits 3,2 ignored, trigger from select regs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= INIT_IDLE;
      end else if (en_in) begin
         if (init_start) begin
            state <= INIT_WAIT_VECTOR;
         end else if (odd_wr_in) begin
            case (state)
               INIT_WAIT_VECTOR: state <= INIT_WAIT_CASCADE;
               INIT_WAIT_CASCADE: state <= INIT_WAIT_FOUR;
               INIT_WAIT_FOUR: state <= INIT_IDLE;
               default: state <= INIT_IDLE;
            endcase
         end
      end
   end
   // init-word stores, write-only from the host's view
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         vector_base <= 8'h00;
         cascade_out <= 8'h00;
         init_four <= INIT_WORD_FOUR_RESET;
      end else if (en_in && odd_wr_in) begin
         case (state)
            INIT_WAIT_VECTOR: vector_base <= {wdata_in[7:3], 3'h0};
            INIT_WAIT_CASCADE: cascade_out <= wdata_in;
            INIT_WAIT_FOUR: init_four <= wdata_in;
            default: vector_base <= vector_base;
         endcase
      end
   end
   // mask: cleared by init, written once idle
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_mask_out <= IRQ_MASK_RESET;
      end else if (en_in) begin
         if (init_start) begin
            irq_mask_out <= IRQ_MASK_RESET;
         end else if (odd_wr_in && state == INIT_IDLE) begin
            irq_mask_out <= wdata_in;
         end
      end
   end
   // operation words, steered by bit 3 when bit 4 is clear
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         op_two <= OP_WORD_TWO_RESET;
         op_word_three_out <= OP_WORD_THREE_RESET;
         slave_addr <= SLAVE_ADDR_RESET;
         lowest_prio <= LOWEST_PRIO_RESET;
      end else if (en_in) begin
         if (init_start) begin
            slave_addr <= SLAVE_ADDR_RESET;
            lowest_prio <= LOWEST_PRIO_RESET;
            // clears special mask and selects pending-request status read
            op_word_three_out <= OP_WORD_THREE_RESET;
         end else if (even_wr_in) begin
            if (wdata_in[OP_WORD_SELECT_BIT]) begin
               op_word_three_out <= wdata_in;
            end else begin
               op_two <= wdata_in;
            end
         end
      end
   end
   // vector: base plus level index of serviced input
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         vector_out <= 8'h00;
         pending_out <= 8'h00;
         initialising_out <= 1'b0;
      end else if (en_in) begin
         vector_out <= {vector_base[7:3], ack_level_in};
         pending_out <= req_in;
         initialising_out <= (state != INIT_IDLE) || init_start;
      end
   end
endmodule
`default_nettype wire

//--- rtl/pic_device.sv
// Purpose: cascaded controller pair with port decode and trigger regs
// Assumes: io strobes one cycle, read data the cycle after
// Notes: priority resolution is lowest-index-first, unmasked only
`timescale 1ns/1ns
`default_nettype none
module pic_device (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic en_in,
   pic_link_if.device link
);
   import pic_pkg::*;
   logic m_even, m_odd, s_even, s_odd, m_trig, s_trig;
   logic [7:0] m_mask, s_mask, m_op3, s_op3, m_vec, s_vec, m_casc, s_casc;
   logic [7:0] m_pend, s_pend;
   logic [7:0] m_trigger, s_trigger;
   logic [7:0] next_rdata;
   logic [7:0] m_req, s_req, m_live, s_live;
   logic [2:0] m_level, s_level;
   logic m_any, s_any;
   logic ack_prev, ack_second;
   logic [2:0] bcast_id;
   // ----------------------------------------------------------------
   // port decode with aliases
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
      hit = ((a & ALIAS_BLOCK_MASK) == (base & ALIAS_BLOCK_MASK)) && a[1:0] == base[1:0];
   endfunction
   assign m_even = hit(link.io_addr, MASTER_EVEN_PORT);
   assign m_odd = hit(link.io_addr, MASTER_ODD_PORT);
   assign s_even = hit(link.io_addr, SLAVE_EVEN_PORT);
   assign s_odd = hit(link.io_addr, SLAVE_ODD_PORT);
   assign m_trig = link.io_addr == MASTER_TRIGGER_PORT;
   assign s_trig = link.io_addr == SLAVE_TRIGGER_PORT;
   // ----------------------------------------------------------------
   // trigger select registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         m_trigger <= TRIGGER_RESET;
         s_trigger <= TRIGGER_RESET;
      end else if (en_in && link.io_wr) begin
         if (m_trig) m_trigger <= link.io_wdata;
         if (s_trig) s_trigger <= link.io_wdata;
      end
   end
   // edge inputs are latched on rise; level inputs follow the line
   logic [7:0] m_prev, s_prev, m_edge, s_edge;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         m_prev <= 8'h00;
         s_prev <= 8'h00;
         m_edge <= 8'h00;
         s_edge <= 8'h00;
      end else if (en_in) begin
         m_prev <= link.irq_lines;
         s_prev <= link.slave_irq_lines;
         // set wins over the acknowledge clear
         m_edge <= (m_edge & ~((ack_second && m_level != 3'h2 ? 8'h01 << m_level : 8'h00)))
                   | (link.irq_lines & ~m_prev);
         s_edge <= (s_edge & ~((ack_second && m_level == 3'h2 ? 8'h01 << s_level : 8'h00)))
                   | (link.slave_irq_lines & ~s_prev);
      end
   end
   assign s_req = (s_trigger & link.slave_irq_lines) | (~s_trigger & s_edge);
   assign s_live = s_req & ~s_mask;
   assign m_req = ((m_trigger & link.irq_lines) | (~m_trigger & m_edge))
                  | {5'h00, s_live != 8'h00, 2'h0}; // slave cascades on input 2
   assign m_live = m_req & ~m_mask;
   // lowest index wins; full priority rotation is out of scope
   always_comb begin
      m_level = 3'h0;
      s_level = 3'h0;
      m_any = 1'b0;
      s_any = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (m_live[i]) begin
            m_level = 3'(i);
            m_any = 1'b1;
         end
         if (s_live[i]) begin
            s_level = 3'(i);
            s_any = 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // the two controllers
   // ----------------------------------------------------------------
   pic_unit master_unit (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .en_in(en_in),
      .even_wr_in(link.io_wr && m_even),
      .odd_wr_in(link.io_wr && m_odd),
      .wdata_in(link.io_wdata),
      .req_in(m_req),
      .ack_level_in(m_level),
      .irq_mask_out(m_mask),
      .op_word_three_out(m_op3),
      .vector_out(m_vec),
      .cascade_out(m_casc),
      .initialising_out(),
      .pending_out(m_pend)
   );
   pic_unit slave_unit (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .en_in(en_in),
      .even_wr_in(link.io_wr && s_even),
      .odd_wr_in(link.io_wr && s_odd),
      .wdata_in(link.io_wdata),
      .req_in(s_req),
      .ack_level_in(s_level),
      .irq_mask_out(s_mask),
      .op_word_three_out(s_op3),
      .vector_out(s_vec),
      .cascade_out(s_casc),
      .initialising_out(),
      .pending_out(s_pend)
   );
   // ----------------------------------------------------------------
   // read path: even port returns pending register (status default)
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = IDLE_READ_DATA;
      if (m_even) next_rdata = m_pend;
      else if (m_odd) next_rdata = m_mask;
      else if (s_even) next_rdata = s_pend;
      else if (s_odd) next_rdata = s_mask;
      else if (m_trig) next_rdata = m_trigger;
      else if (s_trig) next_rdata = s_trigger;
   end
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         link.io_rdata <= 8'h00;
      end else if (en_in && link.io_rd) begin
         link.io_rdata <= next_rdata;
      end
   end
   // ----------------------------------------------------------------
   // acknowledge: second low pulse returns the vector
   // ----------------------------------------------------------------
   assign ack_second = !link.irq_acknowledge_n && ack_prev;
   assign bcast_id = m_casc[2] && m_level == 3'h2 ? 3'h2 : 3'h7;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ack_prev <= 1'b0;
         link.ack_vector <= 8'h00;
         link.ack_vector_valid <= 1'b0;
         link.cpu_irq_out <= 1'b0;
      end else if (en_in) begin
         // a pulse toggles first/second; reset back after the second
         if (!link.irq_acknowledge_n) ack_prev <= !ack_prev;
         link.ack_vector_valid <= ack_second;
         if (ack_second) begin
            // slave answers only on an id match with broadcast code
            if (bcast_id == s_casc[2:0]) link.ack_vector <= {s_vec[7:3], s_level};
            else link.ack_vector <= {m_vec[7:3], m_level};
         end
         link.cpu_irq_out <= m_any;
      end
   end
   logic unused;
   assign unused = ^{m_op3, s_op3, s_any};
endmodule
`default_nettype wire

//--- rtl/pic_host.sv
// Purpose: host end: runs init sequence, I/O and acknowledge cycles
// Assumes: device answers reads one cycle later
// Notes: user asks for init or ack; raw I/O passes through
`timescale 1ns/1ns
`default_nettype none
module pic_host (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic [1:0] cmd_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [15:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   output logic busy_out,
   output logic [7:0] rdata_out,
   output logic [7:0] vector_out,
   output logic vector_valid_out,
   output logic irq_out,
   pic_link_if.host link
);
   import pic_pkg::*;
   logic [3:0] step;
   logic [1:0] ack_step;
   // ----------------------------------------------------------------
   // init script: master then slave, four words each
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         step <= 4'h0;
         ack_step <= 2'h0;
         busy_out <= 1'b0;
         link.io_wr <= 1'b0;
         link.io_rd <= 1'b0;
         link.io_addr <= 16'h0000;
         link.io_wdata <= 8'h00;
         link.irq_acknowledge_n <= 1'b1;
      end else if (en_in) begin
         link.io_wr <= 1'b0;
         link.io_rd <= 1'b0;
         link.irq_acknowledge_n <= 1'b1;
         if (step != 4'h0) begin
            link.io_wr <= 1'b1;
            step <= step + 4'h1;
            case (step)
               4'h1: begin link.io_addr <= MASTER_EVEN_PORT; link.io_wdata <= INIT_WORD_ONE_VALUE; end
               4'h2: begin link.io_addr <= MASTER_ODD_PORT; link.io_wdata <= MASTER_VECTOR_BASE; end
               4'h3: begin link.io_addr <= MASTER_ODD_PORT; link.io_wdata <= MASTER_CASCADE_VALUE; end
               4'h4: begin link.io_addr <= MASTER_ODD_PORT; link.io_wdata <= INIT_WORD_FOUR_VALUE; end
               4'h5: begin link.io_addr <= SLAVE_EVEN_PORT; link.io_wdata <= INIT_WORD_ONE_VALUE; end
               4'h6: begin link.io_addr <= SLAVE_ODD_PORT; link.io_wdata <= SLAVE_VECTOR_BASE; end
               4'h7: begin link.io_addr <= SLAVE_ODD_PORT; link.io_wdata <= SLAVE_ID_VALUE; end
               4'h8: begin link.io_addr <= SLAVE_ODD_PORT; link.io_wdata <= INIT_WORD_FOUR_VALUE; end
               default: begin link.io_wr <= 1'b0; step <= 4'h0; busy_out <= 1'b0; end
            endcase
         end else if (ack_step != 2'h0) begin
            // two acknowledge pulses with an idle cycle between
            ack_step <= ack_step + 2'h1;
            link.irq_acknowledge_n <= ack_step[0];
            if (ack_step == 2'h3) busy_out <= 1'b0;
         end else if (cmd_in == CMD_INIT) begin
            step <= 4'h1;
            busy_out <= 1'b1;
         end else if (cmd_in == CMD_ACK) begin
            ack_step <= 2'h1;
            busy_out <= 1'b1;
            link.irq_acknowledge_n <= 1'b0;
         end else begin
            link.io_wr <= io_wr_in;
            link.io_rd <= io_rd_in && !io_wr_in;
            link.io_addr <= io_addr_in;
            link.io_wdata <= io_wdata_in;
         end
      end
   end
   // answers back to the user
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
         vector_out <= 8'h00;
         vector_valid_out <= 1'b0;
         irq_out <= 1'b0;
      end else if (en_in) begin
         rdata_out <= link.io_rdata;
         vector_valid_out <= link.ack_vector_valid;
         if (link.ack_vector_valid) vector_out <= link.ack_vector;
         irq_out <= link.cpu_irq_out;
      end
   end
endmodule
`default_nettype wire

//--- test/pic_link_monitor.sv
// Purpose: wire checks between host end and controller pair
// Assumes: device enable held high, port decode from the package
// Notes: shadows mirror init steps, masks, bases, trigger regs
`timescale 1ns/1ns
`default_nettype none
module pic_link_monitor
   import pic_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic irq_acknowledge_n,
   input wire logic [7:0] ack_vector,
   input wire logic ack_vector_valid,
   input wire logic cpu_irq_out
);
   // --------------------------------------------------------------
   // shadow state
   // --------------------------------------------------------------
   logic hit, tr, c, odd, ack_prev, ack_phase;
   logic [1:0] step [2];
   logic [7:0] base [2];
   logic [7:0] mask [2];
   logic [7:0] trig [2];
   logic [7:0] rd_mask;
   // aliases: same 32-byte block, low two bits 00 or 01
   assign hit = ((io_addr & ALIAS_BLOCK_MASK) == MASTER_EVEN_PORT
      || (io_addr & ALIAS_BLOCK_MASK) == SLAVE_EVEN_PORT) && !io_addr[1];
   assign tr = io_addr == MASTER_TRIGGER_PORT || io_addr == SLAVE_TRIGGER_PORT;
   assign c = io_addr[7];
   assign odd = io_addr[0];
   assign rd_mask = mask[c];
   // mirror of host writes; step 0 means init finished
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         step <= '{2'h0, 2'h0};
         mask <= '{8'h00, 8'h00};
         base <= '{8'h00, 8'h00};
         trig <= '{8'h00, 8'h00};
      end else if (io_wr && hit) begin
         if (!odd && io_wdata[INIT_SELECT_BIT]) begin
            step[c] <= 2'h1;
            mask[c] <= IRQ_MASK_RESET;
         end else if (odd && step[c] != 2'h0) begin
            step[c] <= step[c] + 2'h1;
            if (step[c] == 2'h1)
               base[c] <= io_wdata;
         end else if (odd) begin
            mask[c] <= io_wdata;
         end
      end else if (io_wr && tr) begin
         trig[io_addr[0]] <= io_wdata;
      end
   end
   // acknowledge pulse pairing: phase high between first and second
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ack_prev <= 1'b1;
         ack_phase <= 1'b0;
      end else begin
         ack_prev <= irq_acknowledge_n;
         if (ack_prev && !irq_acknowledge_n)
            ack_phase <= !ack_phase;
      end
   end
   // --------------------------------------------------------------
   // properties
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence second_low;
      ack_prev && !irq_acknowledge_n && ack_phase;
   endsequence
   sequence one_pulse;
      ack_vector_valid ##1 !ack_vector_valid;
   endsequence
   trig_master_a: assert property (
      io_rd && io_addr == MASTER_TRIGGER_PORT |=> io_rdata == $past(trig[0]))
      else $error("master trigger readback wrong");
   trig_slave_a: assert property (
      io_rd && io_addr == SLAVE_TRIGGER_PORT |=> io_rdata == $past(trig[1]))
      else $error("slave trigger readback wrong");
   unmapped_read_a: assert property (
      io_rd && !hit && !tr |=> io_rdata == IDLE_READ_DATA)
      else $error("unmapped read not idle data");
   mask_read_a: assert property (
      io_rd && hit && odd && step[c] == 2'h0 |=> io_rdata == $past(rd_mask))
      else $error("mask readback wrong");
   ack_answer_a: assert property (
      second_low |-> ##[1:2] ack_vector_valid)
      else $error("no vector after second acknowledge");
   ack_pulse_a: assert property (
      ack_vector_valid |-> one_pulse and !ack_phase)
      else $error("vector valid out of place");
   vector_base_a: assert property (
      ack_vector_valid |-> ack_vector[7:3] == base[0][7:3] || ack_vector[7:3] == base[1][7:3])
      else $error("vector base bits wrong");
   masked_quiet_a: assert property (
      mask[0] == 8'hff && $past(mask[0]) == 8'hff |-> !cpu_irq_out)
      else $error("request raised while fully masked");
endmodule
`default_nettype wire

//--- test/cascaded_pic_port_map_init_test.sv
// Purpose: drives the host user side, checks registers and vectors
// Assumes: host forwards raw I/O one clock after its inputs
// Notes: requests are edge triggered; trigger regs left at 00h
`timescale 1ns/1ns
`default_nettype none
module cascaded_pic_port_map_init_test;
   import pic_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic io_wr_in = 1'b0;
   logic io_rd_in = 1'b0;
   logic [1:0] cmd_in = CMD_NONE;
   logic [15:0] io_addr_in = 16'h0000;
   logic [7:0] io_wdata_in = 8'h00;
   logic busy_out, vector_valid_out, irq_out;
   logic [7:0] rdata_out, vector_out;
   int n_errors = 0;
   int samples_checked = 0;
   int k;
   pic_link_if lnk ();
   pic_host i_pic_host (.clk_sys_in, .rst_in, .en_in(1'b1), .cmd_in, .io_wr_in, .io_rd_in,
      .io_addr_in, .io_wdata_in, .busy_out, .rdata_out, .vector_out, .vector_valid_out,
      .irq_out, .link(lnk));
   pic_device i_pic_device (.clk_sys_in, .rst_in, .en_in(1'b1), .link(lnk));
   pic_link_monitor i_pic_link_monitor (.clk_sys_in, .rst_in, .io_addr(lnk.io_addr),
      .io_wdata(lnk.io_wdata), .io_wr(lnk.io_wr), .io_rd(lnk.io_rd), .io_rdata(lnk.io_rdata),
      .irq_acknowledge_n(lnk.irq_acknowledge_n), .ack_vector(lnk.ack_vector),
      .ack_vector_valid(lnk.ack_vector_valid), .cpu_irq_out(lnk.cpu_irq_out));
   // 10 MHz system clock
   always #50 clk_sys_in = ~clk_sys_in;
   // --------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      io_addr_in <= a;
      io_wdata_in <= d;
      io_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      io_wr_in <= 1'b0;
   endtask
   // data reaches rdata_out two edges after the host takes the strobe
   task automatic read_check(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      io_addr_in <= a;
      io_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      io_rd_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      check(rdata_out, exp);
   endtask
   // CMD_NONE just waits for the host to go idle
   task automatic run(input logic [1:0] c);
      int i;
      @(posedge clk_sys_in);
      cmd_in <= c;
      @(posedge clk_sys_in);
      cmd_in <= CMD_NONE;
      for (i = 0; i < 300; i++) begin
         @(posedge clk_sys_in);
         #1;
         if (c == CMD_ACK ? vector_valid_out === 1'b1 : busy_out === 1'b0)
            break;
      end
      if (i == 300) begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic ack_expect(input logic [7:0] exp);
      run(CMD_ACK);
      check(vector_out, exp);
      run(CMD_NONE);
   endtask
   task automatic settle();
      repeat (4) @(posedge clk_sys_in);
      #1;
   endtask
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      lnk.irq_lines = 8'h00;
      lnk.slave_irq_lines = 8'h00;
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      read_check(MASTER_TRIGGER_PORT, TRIGGER_RESET);
      read_check(SLAVE_ODD_PORT, IRQ_MASK_RESET);
      read_check(16'h0022, IDLE_READ_DATA);
      io_write(SLAVE_TRIGGER_PORT, 8'h5a);
      read_check(SLAVE_TRIGGER_PORT, 8'h5a);
      read_check(MASTER_TRIGGER_PORT, TRIGGER_RESET);
      io_write(SLAVE_TRIGGER_PORT, 8'h00);
      run(CMD_INIT);
      io_write(16'h00bd, 8'h5a);
      read_check(SLAVE_ODD_PORT, 8'h5a);
      io_write(SLAVE_ODD_PORT, 8'h00);
      // master levels; level 2 carries the slave
      for (k = 0; k < 8; k++) begin
         if (k != 2) begin
            @(posedge clk_sys_in);
            lnk.irq_lines <= 8'(8'h01 << k);
            settle();
            check({7'h00, irq_out}, 8'h01);
            ack_expect(MASTER_VECTOR_BASE | 8'(k));
            @(posedge clk_sys_in);
            lnk.irq_lines <= 8'h00;
         end
      end
      // full mask hides a request, op word writes leave the mask alone
      io_write(16'h0039, 8'hff);
      io_write(MASTER_EVEN_PORT, 8'h08);
      lnk.irq_lines <= 8'h80;
      settle();
      check({7'h00, irq_out}, 8'h00);
      read_check(MASTER_ODD_PORT, 8'hff);
      // re-init through aliases, ignored bits 3 and 2 set
      io_write(16'h003c, 8'h1d);
      io_write(16'h003d, 8'h48);
      io_write(16'h003d, MASTER_CASCADE_VALUE);
      io_write(16'h003d, INIT_WORD_FOUR_VALUE);
      read_check(MASTER_ODD_PORT, 8'h00);
      ack_expect(8'h4f);
      @(posedge clk_sys_in);
      lnk.irq_lines <= 8'h00;
      // slave levels through the cascade
      for (k = 0; k < 8; k++) begin
         @(posedge clk_sys_in);
         lnk.slave_irq_lines <= 8'(8'h01 << k);
         settle();
         ack_expect(SLAVE_VECTOR_BASE | 8'(k));
         @(posedge clk_sys_in);
         lnk.slave_irq_lines <= 8'h00;
      end
      test_done();
   end
endmodule
`default_nettype wire
